// ### src/desc_builder.sv
// APB-programmed builder that issues checked descriptor dwords 4 and 5
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "surf_desc_defs.svh"
module desc_builder (
  // Clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        CE,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Descriptor port
  output logic      [31:0] DESC_DW4,
  output logic      [31:0] DESC_DW5,
  output logic             DESC_VALID,
  input  wire logic        DESC_READY
);
  surf_desc_pkg::state_type state_r;
  logic [31:0] surf_r;
  logic [31:0] geom_r;
  logic [31:0] flda_r;
  logic [31:0] fldb_r;
  logic [31:0] rmin_r;
  logic [31:0] prdata_r;
  logic [31:0] dw4_r;
  logic [31:0] dw5_r;
  logic [15:0] viol_r;
  logic [15:0] viol_w;
  logic [31:0] dw4_w;
  logic [31:0] dw5_w;
  logic [31:0] rdata_nxt;
  logic        pready_r;
  logic        pslverr_r;
  logic        valid_r;
  logic        done_r;
  logic        refused_r;
  logic        access;
  logic        wr_go;
  logic        mapped;
  logic        build_req;
  logic        clear_req;

  // Access phase; answer comes one cycle after the first access cycle
  assign access = PSEL & PENABLE;
  assign wr_go = access & pready_r & PWRITE;
  assign build_req = wr_go && PADDR == `OFS_CTRL && PWDATA[`CT_BUILD];
  assign clear_req = wr_go && PADDR == `OFS_CTRL && PWDATA[`CT_CLEAR];

  // Field checker
  desc_check u_check (
    .kind     (surf_r[`SF_KIND_LSB +: 3]),
    .flags    (surf_r[11:0]),
    .depth    (geom_r[`GM_DEPTH_LSB +: 11]),
    .height   (geom_r[`GM_HEIGHT_LSB +: 14]),
    .rot      (flda_r[`FA_ROT_LSB +: 2]),
    .min_arr  (flda_r[`FA_ARR_LSB +: 11]),
    .view_ext (flda_r[`FA_EXT_LSB +: 11]),
    .fmt      (flda_r[`FA_FMT_BIT]),
    .nsamp    (flda_r[`FA_NS_LSB +: 3]),
    .xoff     (fldb_r[`FB_XOFF_LSB +: 9]),
    .yoff     (fldb_r[`FB_YOFF_LSB +: 5]),
    .min_lod  (fldb_r[`FB_MLOD_LSB +: 4]),
    .mip_lod  (fldb_r[`FB_MIP_LSB +: 4]),
    .res_lod  (rmin_r[11:0]),
    .viol     (viol_w)
  );

  // Dword packer
  desc_pack u_pack (
    .rot      (flda_r[`FA_ROT_LSB +: 2]),
    .min_arr  (flda_r[`FA_ARR_LSB +: 11]),
    .view_ext (flda_r[`FA_EXT_LSB +: 11]),
    .fmt      (flda_r[`FA_FMT_BIT]),
    .nsamp    (flda_r[`FA_NS_LSB +: 3]),
    .xoff     (fldb_r[`FB_XOFF_LSB +: 9]),
    .yoff     (fldb_r[`FB_YOFF_LSB +: 5]),
    .min_lod  (fldb_r[`FB_MLOD_LSB +: 4]),
    .mip_lod  (fldb_r[`FB_MIP_LSB +: 4]),
    .yuv422   (surf_r[`SF_YUV422]),
    .dw4      (dw4_w),
    .dw5      (dw5_w)
  );

  // Read decode
  always_comb begin
    mapped = 1'b1;
    rdata_nxt = `RST_WORD;
    unique case (PADDR)
      `OFS_CTRL: rdata_nxt = `RST_WORD;
      `OFS_SURF: rdata_nxt = surf_r;
      `OFS_GEOM: rdata_nxt = geom_r;
      `OFS_FLDA: rdata_nxt = flda_r;
      `OFS_FLDB: rdata_nxt = fldb_r;
      `OFS_RMIN: rdata_nxt = rmin_r;
      `OFS_STAT: begin
        rdata_nxt[`ST_BUSY] = state_r != surf_desc_pkg::st_idle;
        rdata_nxt[`ST_DONE] = done_r;
        rdata_nxt[`ST_REFUSED] = refused_r;
        rdata_nxt[`ST_VIOL_LSB +: 16] = viol_r;
      end
      `OFS_DW4: rdata_nxt = dw4_r;
      `OFS_DW5: rdata_nxt = dw5_r;
      default: mapped = 1'b0;
    endcase
  end

  // APB answer: one wait cycle, error flag for unmapped words
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `RST_WORD;
    end else if (CE) begin
      pready_r <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & ~mapped;
      if (access & ~pready_r & ~PWRITE) begin
        prdata_r <= rdata_nxt;
      end
    end
  end

  // Field registers; narrow fields keep unused bits zero on read
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      surf_r <= `RST_WORD;
      geom_r <= `RST_WORD;
      flda_r <= `RST_WORD;
      fldb_r <= `RST_WORD;
      rmin_r <= `RST_WORD;
    end else if (CE && wr_go && state_r == surf_desc_pkg::st_idle) begin
      // Fields freeze while a build is in flight so checked and sent agree
      unique case (PADDR)
        `OFS_SURF: surf_r <= {20'h0, PWDATA[11:0]};
        `OFS_GEOM: geom_r <= {7'h0, PWDATA[24:0]};
        `OFS_FLDA: flda_r <= {4'h0, PWDATA[27:0]};
        `OFS_FLDB: fldb_r <= {10'h0, PWDATA[21:0]};
        `OFS_RMIN: rmin_r <= {20'h0, PWDATA[11:0]};
        default: ;
      endcase
    end
  end

  // Build sequence: check, then issue or refuse
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_r <= surf_desc_pkg::st_idle;
      valid_r <= 1'b0;
      viol_r <= 16'h0000;
    end else if (CE) begin
      unique case (state_r)
        surf_desc_pkg::st_idle: begin
          // A build order while busy is simply dropped
          if (build_req) begin
            state_r <= surf_desc_pkg::st_check;
          end
        end
        surf_desc_pkg::st_check: begin
          viol_r <= viol_w;
          if (viol_w == 16'h0000) begin
            valid_r <= 1'b1;
            state_r <= surf_desc_pkg::st_issue;
          end else begin
            state_r <= surf_desc_pkg::st_idle;
          end
        end
        surf_desc_pkg::st_issue: begin
          // Hold until the engine side takes the dwords
          if (DESC_READY) begin
            valid_r <= 1'b0;
            state_r <= surf_desc_pkg::st_idle;
          end
        end
        default: state_r <= surf_desc_pkg::st_idle;
      endcase
    end
  end

  // Dwords are captured at check time and stay stable while offered
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      dw4_r <= `RST_WORD;
      dw5_r <= `RST_WORD;
    end else if (CE && state_r == surf_desc_pkg::st_check && viol_w == 16'h0000) begin
      dw4_r <= dw4_w;
      dw5_r <= dw5_w;
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end else if (CE) begin
      if (state_r == surf_desc_pkg::st_issue && DESC_READY) begin
        done_r <= 1'b1;
      end else if (clear_req) begin
        done_r <= 1'b0;
      end
      if (state_r == surf_desc_pkg::st_check && viol_w != 16'h0000) begin
        refused_r <= 1'b1;
      end else if (clear_req) begin
        refused_r <= 1'b0;
      end
    end
  end

  // Outputs straight from flops
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign DESC_DW4 = dw4_r;
  assign DESC_DW5 = dw5_r;
  assign DESC_VALID = valid_r;

  // Checks on issued descriptors
  a_reserved_rotation: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID |-> DESC_DW4[`D4_ROT_LSB +: 2] != 2'h2)
    else $error("reserved rotation code issued");
  a_reserved_bits_zero: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID |-> ((DESC_DW4 & `D4_RSVD_MASK) == `RST_WORD &&
                    (DESC_DW5 & `D5_RSVD_MASK) == `RST_WORD))
    else $error("reserved descriptor bit set");
  a_single_fmt_clear: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && DESC_DW4[`D4_NS_LSB +: 3] == 3'h0 |-> !DESC_DW4[`D4_FMT_BIT])
    else $error("storage bit set at single sample");
  a_ms_lod_zero: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && DESC_DW4[`D4_NS_LSB +: 3] != 3'h0 |->
      DESC_DW5[`D5_MLOD_LSB +: 4] == 4'h0 && DESC_DW5[`D5_MIP_LSB +: 4] == 4'h0)
    else $error("LOD nonzero on multisampled surface");
  a_linear_no_xoff: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && surf_r[`SF_LINEAR] |-> DESC_DW5[`D5_XOFF_LSB +: 7] == 7'h00)
    else $error("X origin on linear surface");
  a_rot_needs_xtile: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && DESC_DW4[`D4_ROT_LSB +: 2] != 2'h0 |-> surf_r[`SF_TILEX])
    else $error("rotation without X-major tiling");
  a_fault_blocks_issue: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && state_r == surf_desc_pkg::st_check && viol_w != 16'h0000 |=>
      !DESC_VALID && refused_r)
    else $error("faulty descriptor issued");
  a_clean_issues: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && state_r == surf_desc_pkg::st_check && viol_w == 16'h0000 |=>
      DESC_VALID && DESC_DW4 == $past(dw4_w) && DESC_DW5 == $past(dw5_w))
    else $error("clean descriptor not issued");
  a_hold_until_taken: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && !DESC_READY |=> DESC_VALID && $stable(DESC_DW4) && $stable(DESC_DW5))
    else $error("descriptor dropped before taken");

  // Duties of the far side that a refusal must keep away from the engine
  a_rot_not_on_uav: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && DESC_DW4[`D4_ROT_LSB +: 2] != 2'h0 |-> !surf_r[`SF_UAV])
    else $error("rotation on typed unordered view");
  a_cube_in_range: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && surf_r[`SF_KIND_LSB +: 3] == surf_desc_pkg::kind_cube |->
      ({3'h0, DESC_DW4[`D4_ARR_LSB +: 11]} * `CUBE_MUL) <= `ARR_MAX)
    else $error("cube minimum element out of range");
  a_ms_sampling_arr: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && DESC_DW4[`D4_NS_LSB +: 3] != 3'h0 && surf_r[`SF_SAMP] |->
      DESC_DW4[`D4_ARR_LSB +: 11] == 11'h000)
    else $error("minimum element on multisampled sampling surface");
  a_extent_is_depth: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && surf_r[`SF_RT] && surf_r[`SF_KIND_LSB +: 3] != surf_desc_pkg::kind_3d |->
      DESC_DW4[`D4_EXT_LSB +: 11] == geom_r[`GM_DEPTH_LSB +: 11])
    else $error("view extent differs from depth");
  a_sint_single: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && surf_r[`SF_SINTP] |-> DESC_DW4[`D4_NS_LSB +: 3] == 3'h0)
    else $error("signed partial-write target multisampled");
  a_bpp128_no_xoff: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && surf_r[`SF_BPP128] |-> DESC_DW5[`D5_XOFF_LSB +: 7] == 7'h00)
    else $error("X origin at 128 bits per pixel");
  a_mono_no_min_lod: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && surf_r[`SF_MONO] |-> DESC_DW5[`D5_MLOD_LSB +: 4] == 4'h0)
    else $error("minimum LOD on mono surface");
  a_lod_in_range: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID |-> DESC_DW5[`D5_MLOD_LSB +: 4] <= `LOD_MAX &&
      DESC_DW5[`D5_MIP_LSB +: 4] <= `LOD_MAX)
    else $error("LOD field above fourteen");
  a_sample_code_legal: assert property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID |-> DESC_DW4[`D4_NS_LSB +: 3] == surf_desc_pkg::single_sample ||
      DESC_DW4[`D4_NS_LSB +: 3] == surf_desc_pkg::four_samples ||
      DESC_DW4[`D4_NS_LSB +: 3] == surf_desc_pkg::eight_samples)
    else $error("reserved sample count issued");
  a_fields_frozen: assert property (@(posedge CLK) disable iff (!RESETN)
    state_r != surf_desc_pkg::st_idle |=> $stable(surf_r) && $stable(geom_r) &&
      $stable(flda_r) && $stable(fldb_r) && $stable(rmin_r))
    else $error("field changed during a build");
  a_refuse_keeps_last: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && state_r == surf_desc_pkg::st_check && viol_w != 16'h0000 |=>
      $stable(DESC_DW4) && $stable(DESC_DW5))
    else $error("refused build changed issued dwords");

  // Bus answer lasts one cycle; a low enable must freeze it mid-transfer
  a_ready_one_cycle: assert property (@(posedge CLK) disable iff (!RESETN)
    PREADY && CE |=> !PREADY)
    else $error("ready held past one cycle");
  a_err_with_ready: assert property (@(posedge CLK) disable iff (!RESETN)
    PSLVERR |-> PREADY)
    else $error("error flag without ready");
  a_enable_freezes: assert property (@(posedge CLK) disable iff (!RESETN)
    !CE |=> $stable(PREADY) && $stable(DESC_VALID) && $stable(state_r))
    else $error("state moved while disabled");

  // Main scenarios
  c_issue: cover property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && DESC_READY);
  c_refuse: cover property (@(posedge CLK) disable iff (!RESETN)
    $rose(refused_r));
  c_stall: cover property (@(posedge CLK) disable iff (!RESETN)
    DESC_VALID && !DESC_READY ##1 DESC_VALID && DESC_READY);

  // Rarer corners: dropped build order, bus held by a low enable
  c_busy_drop: cover property (@(posedge CLK) disable iff (!RESETN)
    state_r != surf_desc_pkg::st_idle && build_req);
  c_enable_hold: cover property (@(posedge CLK) disable iff (!RESETN)
    !CE && PSEL && PENABLE);
endmodule

// ### pkg/surf_desc_defs.svh
// Offsets, field positions and limits for the descriptor builder
`ifndef SURF_DESC_DEFS_SVH
`define SURF_DESC_DEFS_SVH
`define OFS_CTRL      8'h00
`define OFS_SURF      8'h04
`define OFS_GEOM      8'h08
`define OFS_FLDA      8'h0c
`define OFS_FLDB      8'h10
`define OFS_RMIN      8'h14
`define OFS_STAT      8'h18
`define OFS_DW4       8'h1c
`define OFS_DW5       8'h20
`define RST_WORD      32'h0000_0000
`define CT_BUILD      0
`define CT_CLEAR      1
`define ST_BUSY       0
`define ST_DONE       1
`define ST_REFUSED    2
`define ST_VIOL_LSB   16
`define SF_KIND_LSB   0
`define SF_TILEX      3
`define SF_LINEAR     4
`define SF_BPP128     5
`define SF_YUV422     6
`define SF_SINTP      7
`define SF_MONO       8
`define SF_SAMP       9
`define SF_RT         10
`define SF_UAV        11
`define GM_DEPTH_LSB  0
`define GM_HEIGHT_LSB 11
`define FA_ROT_LSB    0
`define FA_ARR_LSB    2
`define FA_EXT_LSB    13
`define FA_FMT_BIT    24
`define FA_NS_LSB     25
`define FB_XOFF_LSB   0
`define FB_YOFF_LSB   9
`define FB_MLOD_LSB   14
`define FB_MIP_LSB    18
`define D4_ROT_LSB    29
`define D4_ARR_LSB    18
`define D4_EXT_LSB    7
`define D4_FMT_BIT    6
`define D4_NS_LSB     3
`define D5_XOFF_LSB   25
`define D5_YOFF_LSB   20
`define D5_MLOD_LSB   4
`define D5_MIP_LSB    0
`define D4_RSVD_MASK  32'h8000_0007
`define D5_RSVD_MASK  32'h010f_ff00
`define LIM_8X        27'd4194304
`define LIM_4X        27'd8388608
`define LOD_MAX       4'he
`define YOFF_MAX      5'd30
`define ARR_MAX       14'h7ff
`define CUBE_MUL      14'h006
`endif

// ### pkg/surf_desc_pkg.sv
// Types shared by the descriptor builder
package surf_desc_pkg;
  typedef enum logic [1:0] {
    rotation_none          = 2'h0,
    rotation_quarter       = 2'h1,
    rotation_three_quarter = 2'h3
  } rotation_type;
  typedef enum logic [2:0] {
    single_sample = 3'h0,
    four_samples  = 3'h2,
    eight_samples = 3'h3
  } sample_count_type;
  typedef enum logic [2:0] {
    kind_1d = 3'h0, kind_2d = 3'h1, kind_3d = 3'h2, kind_cube = 3'h3,
    kind_buffer = 3'h4, structured_buffer_type = 3'h5
  } surf_kind_type;
  typedef enum logic [1:0] {
    st_idle = 2'b00, st_check = 2'b01, st_issue = 2'b11
  } state_type;
endpackage

// ### src/desc_pack.sv
// Packs programmed fields into descriptor dwords 4 and 5
`timescale 1ns/1ns
`include "surf_desc_defs.svh"
module desc_pack (
  // Fields
  input  wire logic [1:0]  rot,
  input  wire logic [10:0] min_arr,
  input  wire logic [10:0] view_ext,
  input  wire logic        fmt,
  input  wire logic [2:0]  nsamp,
  input  wire logic [8:0]  xoff,
  input  wire logic [4:0]  yoff,
  input  wire logic [3:0]  min_lod,
  input  wire logic [3:0]  mip_lod,
  input  wire logic        yuv422,
  // Dwords
  output logic      [31:0] dw4,
  output logic      [31:0] dw5
);
  logic fmt_eff;
  logic [6:0] xfield;
  // Format bit means nothing at one sample, so send it clear
  assign fmt_eff = fmt & (nsamp != surf_desc_pkg::single_sample);
  // YUV 4:2:2 counts the X origin in pairs, others in quads
  assign xfield = yuv422 ? xoff[7:1] : xoff[8:2];
  // Reserved bits stay zero by construction
  always_comb begin
    dw4 = `RST_WORD;
    dw4[`D4_ROT_LSB +: 2] = rot;
    dw4[`D4_ARR_LSB +: 11] = min_arr;
    dw4[`D4_EXT_LSB +: 11] = view_ext;
    dw4[`D4_FMT_BIT] = fmt_eff;
    dw4[`D4_NS_LSB +: 3] = nsamp;
    dw5 = `RST_WORD;
    dw5[`D5_XOFF_LSB +: 7] = xfield;
    dw5[`D5_YOFF_LSB +: 4] = yoff[4:1];
    dw5[`D5_MLOD_LSB +: 4] = min_lod;
    dw5[`D5_MIP_LSB +: 4] = mip_lod;
  end
endmodule

// ### src/desc_check.sv
// Checks programmed fields against descriptor programming limits
`timescale 1ns/1ns
`include "surf_desc_defs.svh"
module desc_check (
  // Surface
  input  wire logic [2:0]  kind,
  input  wire logic [11:0] flags,
  input  wire logic [10:0] depth,
  input  wire logic [13:0] height,
  // Fields
  input  wire logic [1:0]  rot,
  input  wire logic [10:0] min_arr,
  input  wire logic [10:0] view_ext,
  input  wire logic        fmt,
  input  wire logic [2:0]  nsamp,
  input  wire logic [8:0]  xoff,
  input  wire logic [4:0]  yoff,
  input  wire logic [3:0]  min_lod,
  input  wire logic [3:0]  mip_lod,
  input  wire logic [11:0] res_lod,
  // Result
  output logic      [15:0] viol
);
  logic ms;
  logic big;
  logic [26:0] area;
  logic [13:0] cube_arr;
  assign ms = nsamp != surf_desc_pkg::single_sample;
  // Depth and height both carry minus one
  assign area = 27'({1'b0, depth} + 12'h001) * 27'({1'b0, height} + 15'h0001);
  assign big = (nsamp == surf_desc_pkg::eight_samples && area > `LIM_8X) ||
               (nsamp == surf_desc_pkg::four_samples && area > `LIM_4X);
  assign cube_arr = {3'h0, min_arr} * `CUBE_MUL;
  // One bit per refused condition; bit 15 covers both cube range and reserved sample code
  always_comb begin
    viol = 16'h0000;
    viol[0] = rot == 2'h2;
    viol[1] = rot != surf_desc_pkg::rotation_none && !flags[`SF_TILEX];
    viol[2] = rot != surf_desc_pkg::rotation_none && flags[`SF_UAV];
    viol[3] = ms && flags[`SF_SAMP] && min_arr != 11'h000;
    viol[4] = flags[`SF_RT] && kind != surf_desc_pkg::kind_3d && view_ext != depth;
    viol[5] = ms && flags[`SF_RT] && fmt && !big;
    viol[6] = big && !fmt;
    viol[7] = ms && (min_lod != 4'h0 || mip_lod != 4'h0 || res_lod != 12'h000);
    viol[8] = ms && flags[`SF_SINTP];
    viol[9] = flags[`SF_LINEAR] && xoff != 9'h000;
    viol[10] = flags[`SF_BPP128] && xoff != 9'h000;
    viol[11] = flags[`SF_YUV422] ? (xoff[0] || xoff[8]) : (xoff[1:0] != 2'h0);
    viol[12] = yoff[0] || yoff > `YOFF_MAX;
    viol[13] = flags[`SF_MONO] && min_lod != 4'h0;
    viol[14] = min_lod > `LOD_MAX || mip_lod > `LOD_MAX;
    viol[15] = (kind == surf_desc_pkg::kind_cube && cube_arr > `ARR_MAX) ||
               (ms && nsamp != surf_desc_pkg::four_samples &&
                nsamp != surf_desc_pkg::eight_samples);
  end
endmodule

// ### verif/engine_model.sv
// Engine-side consumer model for issued descriptor dwords
`timescale 1ns/1ns
`include "surf_desc_defs.svh"
module engine_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Descriptor port
  input  wire logic [31:0] dw4,
  input  wire logic [31:0] dw5,
  input  wire logic        valid,
  output logic             ready,
  // Control and observation
  input  wire logic [7:0]  stall,
  output logic      [31:0] got4,
  output logic      [31:0] got5,
  output logic      [15:0] taken,
  output logic             fault
);
  logic [7:0]  wait_r;
  logic [31:0] held4_r;
  logic [31:0] held5_r;
  logic        offered_r;

  // Prompt or slow acceptance; ready lasts one cycle per handshake
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ready  <= 1'b0;
      wait_r <= 8'h00;
    end else if (valid && !ready) begin
      if (wait_r >= stall) begin
        ready <= 1'b1;
      end else begin
        wait_r <= wait_r + 8'h01;
      end
    end else begin
      ready  <= 1'b0;
      wait_r <= 8'h00;
    end
  end

  // Both dwords are latched together at the handshake
  always_ff @(posedge clk) begin
    if (!resetn) begin
      got4  <= 32'h0000_0000;
      got5  <= 32'h0000_0000;
      taken <= 16'h0000;
    end else if (valid && ready) begin
      got4  <= dw4;
      got5  <= dw5;
      taken <= taken + 16'h0001;
    end
  end

  // A torn pair or dirty reserved bits would mislead the engine
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fault     <= 1'b0;
      offered_r <= 1'b0;
    end else begin
      held4_r   <= dw4;
      held5_r   <= dw5;
      offered_r <= valid && !ready;
      if (valid && offered_r && (dw4 !== held4_r || dw5 !== held5_r)) fault <= 1'b1;
      if (valid && ((dw4 & `D4_RSVD_MASK) != 0 || (dw5 & `D5_RSVD_MASK) != 0)) fault <= 1'b1;
    end
  end
endmodule

// ### verif/test_desc_builder.sv
// Self-checking bench for the descriptor builder
`timescale 1ns/1ns
`include "surf_desc_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module test_desc_builder;
  logic        clk;
  logic        resetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] dw4;
  logic [31:0] dw5;
  logic        valid;
  logic        ready;
  logic [7:0]  stall;
  logic [31:0] got4;
  logic [31:0] got5;
  logic [15:0] taken;
  logic        fault;
  logic [31:0] q;
  logic        e;
  logic [15:0] k;
  int          miscompares;
  int          comparisons;

  desc_builder DUT (.CLK(clk), .RESETN(resetn), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DESC_DW4(dw4), .DESC_DW5(dw5), .DESC_VALID(valid),
    .DESC_READY(ready));
  engine_model partner (.clk(clk), .resetn(resetn), .dw4(dw4), .dw5(dw5), .valid(valid),
    .ready(ready), .stall(stall), .got4(got4), .got5(got5), .taken(taken), .fault(fault));

  // Free-running 20 MHz clock
  always #25 clk = ~clk;

  task stop_test;
    $display("TB: %0d miscompares, %0d comparisons", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high or 20 cycles pass
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rq, output logic re);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK(pready, 1'b1)
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic        re;
    apb(1'b1, a, d, rq, re);
  endtask

  // Poll status until done or refused; bounded
  task settle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFS_STAT, 32'h0, q, e);
      n++;
    end while (q[2:1] === 2'b00 && n < 30);
  endtask

  // Program all fields, build, then check status and issued dwords
  task build(input logic [31:0] s, input logic [10:0] d, input logic [13:0] h,
             input logic [1:0] r, input logic [10:0] m, x, input logic f,
             input logic [2:0] n, input logic [8:0] xo, input logic [4:0] yo,
             input logic [3:0] ml, mp, input logic [15:0] v);
    logic [31:0] e4;
    logic [31:0] e5;
    e4 = {1'b0, r, m, x, f & (n != 3'h0), n, 3'h0};
    e5 = {s[6] ? xo[7:1] : xo[8:2], 1'b0, yo[4:1], 12'h000, ml, mp};
    wr(`OFS_SURF, s);
    wr(`OFS_GEOM, {7'h00, h, d});
    wr(`OFS_FLDA, {4'h0, n, f, x, m, r});
    wr(`OFS_FLDB, {10'h000, mp, ml, yo, xo});
    wr(`OFS_RMIN, 32'h0);
    wr(`OFS_CTRL, 32'h2);
    k = taken;
    wr(`OFS_CTRL, 32'h1);
    settle();
    `CHK(q[31:16], v)
    `CHK(q[2], (v != 16'h0))
    if (v == 16'h0) begin
      `CHK(got4, e4)
      `CHK(got5, e5)
      `CHK(taken, k + 16'h1)
      apb(1'b0, `OFS_DW4, 32'h0, q, e);
      `CHK(q, e4)
    end else begin
      `CHK(taken, k)
    end
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  initial begin
    clk = 1'b0; resetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; stall = 8'd2; miscompares = 0; comparisons = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // Quiet after reset, unmapped offsets flagged
    apb(1'b0, `OFS_STAT, 32'h0, q, e);
    `CHK(q, `RST_WORD)
    `CHK(e, 1'b0)
    apb(1'b0, `OFS_DW5, 32'h0, q, e);
    `CHK(q, `RST_WORD)
    `CHK(valid, 1'b0)
    apb(1'b0, 8'h40, 32'h0, q, e);
    `CHK(e, 1'b1)
    apb(1'b1, 8'h3c, 32'h5, q, e);
    `CHK(e, 1'b1)
    // Every rotation code, code 2 refused
    for (int i = 0; i < 4; i++) begin
      build(32'h409, 0, 0, i[1:0], 5, 0, 1, 0, 8, 6, 3, 4, (i == 2) ? 16'h1 : 16'h0);
    end
    build(32'h401, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 16'h2);
    build(32'hc09, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 16'h4);
    // Every sample count code
    for (int i = 0; i < 8; i++) begin
      build(32'h409, 0, 0, 0, 0, 0, i == 0, i[2:0], 0, 0, 0, 0,
            (i == 0 || i == 2 || i == 3) ? 16'h0 : 16'h8000);
    end
    build(32'h609, 0, 0, 0, 1, 0, 0, 3, 0, 0, 0, 0, 16'h8);
    build(32'h409, 0, 0, 0, 0, 0, 0, 2, 0, 0, 1, 0, 16'h80);
    build(32'h409, 0, 0, 0, 0, 0, 0, 3, 0, 0, 0, 1, 16'h80);
    build(32'h489, 0, 0, 0, 0, 0, 0, 2, 0, 0, 0, 0, 16'h100);
    build(32'h409, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 16'h10);
    build(32'h40a, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 16'h0);
    // Size thresholds for storage format, both sides of each limit
    build(32'h409, 2047, 2048, 0, 0, 2047, 0, 3, 0, 0, 0, 0, 16'h40);
    build(32'h409, 2047, 2048, 0, 0, 2047, 1, 3, 0, 0, 0, 0, 16'h0);
    build(32'h409, 2047, 2047, 0, 0, 2047, 1, 3, 0, 0, 0, 0, 16'h20);
    build(32'h409, 2047, 4096, 0, 0, 2047, 0, 2, 0, 0, 0, 0, 16'h40);
    build(32'h409, 2047, 4096, 0, 0, 2047, 1, 2, 0, 0, 0, 0, 16'h0);
    build(32'h409, 2047, 4095, 0, 0, 2047, 1, 2, 0, 0, 0, 0, 16'h20);
    // Origin offsets
    build(32'h411, 0, 0, 0, 0, 0, 0, 0, 4, 0, 0, 0, 16'h200);
    build(32'h409, 0, 0, 0, 0, 0, 0, 0, 508, 30, 0, 0, 16'h0);
    build(32'h429, 0, 0, 0, 0, 0, 0, 0, 4, 0, 0, 0, 16'h400);
    build(32'h409, 0, 0, 0, 0, 0, 0, 0, 6, 0, 0, 0, 16'h800);
    build(32'h449, 0, 0, 0, 0, 0, 0, 0, 6, 0, 0, 0, 16'h0);
    build(32'h409, 0, 0, 0, 0, 0, 0, 0, 0, 7, 0, 0, 16'h1000);
    // Level of detail and cube scaling
    build(32'h509, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 16'h2000);
    build(32'h409, 0, 0, 0, 0, 0, 0, 0, 0, 0, 14, 14, 16'h0);
    build(32'h409, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 15, 16'h4000);
    build(32'h20b, 0, 0, 0, 341, 0, 0, 0, 0, 0, 0, 0, 16'h0);
    build(32'h20b, 0, 0, 0, 342, 0, 0, 0, 0, 0, 0, 0, 16'h8000);
    // Stalled engine: field write and second build ignored while busy
    stall <= 8'd40;
    build(32'h409, 0, 0, 0, 5, 0, 0, 0, 8, 6, 3, 4, 16'h0);
    wr(`OFS_CTRL, 32'h2);
    k = taken;
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_FLDA, 32'h1);
    wr(`OFS_CTRL, 32'h1);
    apb(1'b0, `OFS_STAT, 32'h0, q, e);
    `CHK(q[0], 1'b1)
    `CHK(valid, 1'b1)
    settle();
    `CHK(got4, 32'h0014_0000)
    `CHK(taken, k + 16'h1)
    wr(`OFS_CTRL, 32'h2);
    apb(1'b0, `OFS_STAT, 32'h0, q, e);
    `CHK(q[2:0], 3'h0)
    `CHK(fault, 1'b0)
    // Clock enable low holds the bus answer back until it returns
    ce <= 1'b0;
    fork
      apb(1'b0, `OFS_SURF, 32'h0, q, e);
      begin
        repeat (6) @(posedge clk);
        `CHK(pready, 1'b0)
        ce <= 1'b1;
      end
    join
    `CHK(q, 32'h0000_0409)
    stop_test();
  end
endmodule
